/* File: design/qsr_top.sv */
// APB register front end for the frequency and limit-fail status register sets
//
// What this block does
// - Frequency event read returns the weighted sum of its set bits.
// - Frequency event register clears after being read.
// - Frequency falling filter takes 0..32767, stored bitwise; larger values refused.
// - Frequency rising filter takes 0..32767, stored bit by bit.
// - Filter and mask writes accept MAX and MIN keywords.
// - A written sum sets exactly the bits of its weights.
// - Limit condition read returns its bits and leaves them unchanged.
// - Limit enable mask written 0..32767 and read back.
// - Limit event read returns its bits and clears them.
// - Limit event bits stay zero after a read until new events.
// - Limit falling filter written 0..32767 and read back.
// - Limit rising filter written 0..32767 and read back.
// - Instrument preset leaves filters and masks untouched.
// - Status preset: enables and rising filters all ones, falling filters zero.
// - Frequency condition register readable as weighted sum.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module qsr_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [qsr_pkg::QSR_AW-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [qsr_pkg::QSR_DW-1:0]  pwdata,
  output logic      [qsr_pkg::QSR_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [qsr_pkg::QSR_W-1:0]   freq_cond,
  input  wire logic [qsr_pkg::QSR_W-1:0]   lim_cond,
  output logic                             freq_summary,
  output logic                             lim_summary
);
  localparam int W  = qsr_pkg::QSR_W;
  localparam int NG = qsr_pkg::QSR_NGRP;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic qsr_pkg::qsr_reg_t qsr_dec_reg(input logic [qsr_pkg::QSR_AW-1:0] a);
    qsr_pkg::qsr_reg_t r;
    r = qsr_pkg::QSR_R_NONE;
    if (a < qsr_pkg::QSR_CTRL_OFS) begin
      case (a[4:0])
        qsr_pkg::QSR_OFS_COND:  r = qsr_pkg::QSR_R_COND;
        qsr_pkg::QSR_OFS_EVENT: r = qsr_pkg::QSR_R_EVENT;
        qsr_pkg::QSR_OFS_ENAB:  r = qsr_pkg::QSR_R_ENAB;
        qsr_pkg::QSR_OFS_PTR:   r = qsr_pkg::QSR_R_PTR;
        qsr_pkg::QSR_OFS_NTR:   r = qsr_pkg::QSR_R_NTR;
        default:                r = qsr_pkg::QSR_R_NONE;
      endcase
    end
    return r;
  endfunction : qsr_dec_reg

  qsr_grp_if gif [NG] ();

  logic [W-1:0]           cond_pin  [NG];
  logic [W-1:0]           cond_s1_q [NG];
  logic [W-1:0]           cond_s2_q [NG];
  logic [W-1:0]           cond_a    [NG];
  logic [W-1:0]           evt_a     [NG];
  logic [W-1:0]           enab_a    [NG];
  logic [W-1:0]           ptr_a     [NG];
  logic [W-1:0]           ntr_a     [NG];
  logic [NG-1:0]          summ_a;
  logic [qsr_pkg::QSR_DW-1:0] prdata_q;

  wire                    setup_w    = psel & ~penable;
  wire                    access_w   = psel & penable;
  wire                    grp_idx_w  = paddr[qsr_pkg::QSR_GRP_BIT];
  wire qsr_pkg::qsr_reg_t reg_w      = qsr_dec_reg(paddr);
  wire                    is_ctrl_w  = (paddr == qsr_pkg::QSR_CTRL_OFS);
  wire                    is_summ_w  = (paddr == qsr_pkg::QSR_SUMM_OFS);
  wire [1:0]              bound_w    = pwdata[qsr_pkg::QSR_BND_MSB:qsr_pkg::QSR_BND_LSB];
  wire                    is_filt_w  = (reg_w == qsr_pkg::QSR_R_ENAB) | (reg_w == qsr_pkg::QSR_R_PTR)
                                     | (reg_w == qsr_pkg::QSR_R_NTR);

  // ----------------------------------------------------------------------
  // Write value: number or bound keyword
  // ----------------------------------------------------------------------
  // Values above the 15-bit range are refused rather than truncated, so a
  // misbehaving controller cannot silently set the wrong bits
  wire [W-1:0] val_w = (bound_w == qsr_pkg::QSR_BND_MAX) ? qsr_pkg::QSR_MAX :
                       (bound_w == qsr_pkg::QSR_BND_MIN) ? qsr_pkg::QSR_MIN :
                       pwdata[W-1:0];
  wire range_bad_w = ((bound_w == qsr_pkg::QSR_BND_NUM) & pwdata[W])
                   | (bound_w == qsr_pkg::QSR_BND_RSV);

  wire wr_err_w = pwrite & ~is_ctrl_w & (~is_filt_w | range_bad_w);
  wire rd_err_w = ~pwrite & ~is_ctrl_w & ~is_summ_w & (reg_w == qsr_pkg::QSR_R_NONE);
  wire wr_ok_w  = access_w & pwrite & ~wr_err_w;
  wire preset_w = wr_ok_w & is_ctrl_w & pwdata[qsr_pkg::QSR_PRESET_BIT];
  wire rd_evt_w = access_w & ~pwrite & (reg_w == qsr_pkg::QSR_R_EVENT);

  assign pready  = 1'h1;
  assign pslverr = access_w & (wr_err_w | rd_err_w);
  assign prdata  = prdata_q;

  assign cond_pin[qsr_pkg::QSR_GI_FREQ] = freq_cond;
  assign cond_pin[qsr_pkg::QSR_GI_LIM]  = lim_cond;

  // ----------------------------------------------------------------------
  // Register sets
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NG; g++) begin : g_grp
    // Condition pins are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cond_s1_q[g] <= qsr_pkg::QSR_ZERO;
        cond_s2_q[g] <= qsr_pkg::QSR_ZERO;
      end else begin
        cond_s1_q[g] <= cond_pin[g];
        cond_s2_q[g] <= cond_s1_q[g];
      end
    end

    assign gif[g].cond    = cond_s2_q[g];
    assign gif[g].wr_en   = wr_ok_w & is_filt_w & (grp_idx_w == g[0]);
    assign gif[g].wr_sel  = reg_w;
    assign gif[g].wr_data = val_w;
    assign gif[g].preset  = preset_w;
    // Clear only what was captured for the reader in the setup cycle
    assign gif[g].rd_clr  = (rd_evt_w & (grp_idx_w == g[0])) ? prdata_q[W-1:0]
                                                             : qsr_pkg::QSR_ZERO;

    assign cond_a[g] = gif[g].cond;
    assign evt_a[g]  = gif[g].evt_q;
    assign enab_a[g] = gif[g].enab_q;
    assign ptr_a[g]  = gif[g].ptr_q;
    assign ntr_a[g]  = gif[g].ntr_q;
    assign summ_a[g] = gif[g].summary_q;

    qsr_group u_grp (
      .pclk    (pclk),
      .presetn (presetn),
      .gi      (gif[g])
    );
  end

  assign freq_summary = summ_a[qsr_pkg::QSR_GI_FREQ];
  assign lim_summary  = summ_a[qsr_pkg::QSR_GI_LIM];

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Captured in the setup cycle so read data comes from a flop with no wait state
  wire [W-1:0] sel_val_w = (reg_w == qsr_pkg::QSR_R_COND)  ? cond_a[grp_idx_w] :
                           (reg_w == qsr_pkg::QSR_R_EVENT) ? evt_a[grp_idx_w]  :
                           (reg_w == qsr_pkg::QSR_R_ENAB)  ? enab_a[grp_idx_w] :
                           (reg_w == qsr_pkg::QSR_R_PTR)   ? ptr_a[grp_idx_w]  :
                           (reg_w == qsr_pkg::QSR_R_NTR)   ? ntr_a[grp_idx_w]  :
                           qsr_pkg::QSR_ZERO;
  wire [qsr_pkg::QSR_DW-1:0] prdata_d =
    is_summ_w ? {{(qsr_pkg::QSR_DW-NG){1'h0}}, summ_a} :
                {{(qsr_pkg::QSR_DW-W){1'h0}}, sel_val_w};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_w & ~pwrite) begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_event_read_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && reg_w == qsr_pkg::QSR_R_EVENT)
      |=> prdata[W-1:0] == $past(evt_a[grp_idx_w]))
    else $error("Event read data differs from event register");
  chk_cond_read_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && reg_w == qsr_pkg::QSR_R_COND)
      |=> prdata[W-1:0] == $past(cond_a[grp_idx_w]))
    else $error("Condition read data differs from condition register");
  chk_range_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && is_filt_w && bound_w == qsr_pkg::QSR_BND_NUM && pwdata[W])
      |-> pslverr && !gif[0].wr_en && !gif[1].wr_en)
    else $error("Out of range value was not refused");
  chk_max_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && reg_w == qsr_pkg::QSR_R_PTR && !grp_idx_w && bound_w == qsr_pkg::QSR_BND_MAX)
      |=> ptr_a[qsr_pkg::QSR_GI_FREQ] == qsr_pkg::QSR_MAX)
    else $error("MAX keyword did not set all bits");
  chk_min_bound: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && reg_w == qsr_pkg::QSR_R_ENAB && grp_idx_w && bound_w == qsr_pkg::QSR_BND_MIN)
      |=> enab_a[qsr_pkg::QSR_GI_LIM] == qsr_pkg::QSR_MIN)
    else $error("MIN keyword did not clear all bits");
  chk_sum_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_w && pwrite && reg_w == qsr_pkg::QSR_R_NTR && bound_w == qsr_pkg::QSR_BND_NUM && !pwdata[W])
      |=> ntr_a[$past(grp_idx_w)] == $past(pwdata[W-1:0]))
    else $error("Written sum not stored bit for bit");
  chk_read_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_w && !pwrite && reg_w == qsr_pkg::QSR_R_EVENT && grp_idx_w)
      ##1 (access_w && $stable(cond_s2_q[qsr_pkg::QSR_GI_LIM]))
      |=> (evt_a[qsr_pkg::QSR_GI_LIM] & $past(prdata[W-1:0])) == qsr_pkg::QSR_ZERO)
    else $error("Limit event bits not cleared by read");

endmodule : qsr_top

/* File: design/qsr_pkg.sv */
// Shared constants and types for the questionable status register sets
package qsr_pkg;

  // ----------------------------------------------------------------------
  // Widths and group indices
  // ----------------------------------------------------------------------
  localparam int QSR_W       = 15;
  localparam int QSR_DW      = 32;
  localparam int QSR_AW      = 8;
  localparam int QSR_NGRP    = 2;
  localparam int QSR_GI_FREQ = 0;
  localparam int QSR_GI_LIM  = 1;
  localparam int QSR_GRP_BIT = 5;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [4:0] QSR_OFS_COND  = 5'h00;
  localparam logic [4:0] QSR_OFS_EVENT = 5'h04;
  localparam logic [4:0] QSR_OFS_ENAB  = 5'h08;
  localparam logic [4:0] QSR_OFS_PTR   = 5'h0C;
  localparam logic [4:0] QSR_OFS_NTR   = 5'h10;
  localparam logic [7:0] QSR_CTRL_OFS  = 8'h40;
  localparam logic [7:0] QSR_SUMM_OFS  = 8'h44;
  localparam int         QSR_PRESET_BIT = 0;

  // ----------------------------------------------------------------------
  // Write data bound keyword field
  // ----------------------------------------------------------------------
  localparam int         QSR_BND_LSB = 16;
  localparam int         QSR_BND_MSB = 17;
  localparam logic [1:0] QSR_BND_NUM = 2'h0;
  localparam logic [1:0] QSR_BND_MAX = 2'h1;
  localparam logic [1:0] QSR_BND_MIN = 2'h2;
  localparam logic [1:0] QSR_BND_RSV = 2'h3;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [QSR_W-1:0] QSR_MAX         = 15'h7FFF;
  localparam logic [QSR_W-1:0] QSR_MIN         = 15'h0000;
  localparam logic [QSR_W-1:0] QSR_ENAB_PRESET = 15'h7FFF;
  localparam logic [QSR_W-1:0] QSR_PTR_PRESET  = 15'h7FFF;
  localparam logic [QSR_W-1:0] QSR_NTR_PRESET  = 15'h0000;
  localparam logic [QSR_W-1:0] QSR_ZERO        = 15'h0000;

  typedef enum logic [2:0] {
    QSR_R_COND,
    QSR_R_EVENT,
    QSR_R_ENAB,
    QSR_R_PTR,
    QSR_R_NTR,
    QSR_R_NONE
  } qsr_reg_t;

endpackage : qsr_pkg

/* File: design/qsr_grp_if.sv */
// Connection between the bus front end and one register set
`timescale 1ns/100ps
interface qsr_grp_if;
  logic                        wr_en;
  qsr_pkg::qsr_reg_t           wr_sel;
  logic [qsr_pkg::QSR_W-1:0]   wr_data;
  logic [qsr_pkg::QSR_W-1:0]   rd_clr;
  logic                        preset;
  logic [qsr_pkg::QSR_W-1:0]   cond;
  logic [qsr_pkg::QSR_W-1:0]   evt_q;
  logic [qsr_pkg::QSR_W-1:0]   enab_q;
  logic [qsr_pkg::QSR_W-1:0]   ptr_q;
  logic [qsr_pkg::QSR_W-1:0]   ntr_q;
  logic                        summary_q;

  modport ctl (output wr_en, wr_sel, wr_data, rd_clr, preset, cond,
               input  evt_q, enab_q, ptr_q, ntr_q, summary_q);
  modport grp (input  wr_en, wr_sel, wr_data, rd_clr, preset, cond,
               output evt_q, enab_q, ptr_q, ntr_q, summary_q);
endinterface : qsr_grp_if

/* File: design/qsr_group.sv */
// One register set: transition filters, latched events, enable mask
`timescale 1ns/100ps
module qsr_group (
  input wire logic pclk,
  input wire logic presetn,
  qsr_grp_if.grp   gi
);
  localparam int W = qsr_pkg::QSR_W;

  logic [W-1:0] cond_prev_q;
  logic [W-1:0] set_w;
  logic [W-1:0] evt_d;

  // ----------------------------------------------------------------------
  // Transition detection
  // ----------------------------------------------------------------------
  assign set_w = (gi.cond & ~cond_prev_q & gi.ptr_q)
               | (~gi.cond & cond_prev_q & gi.ntr_q);
  // A bit that latches while being read survives the clear
  assign evt_d = (gi.evt_q & ~gi.rd_clr) | set_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_prev_q  <= qsr_pkg::QSR_ZERO;
      gi.evt_q     <= qsr_pkg::QSR_ZERO;
      gi.summary_q <= 1'h0;
    end else begin
      cond_prev_q  <= gi.cond;
      gi.evt_q     <= evt_d;
      gi.summary_q <= |(gi.evt_q & gi.enab_q);
    end
  end

  // ----------------------------------------------------------------------
  // Filters and mask; only status preset or a write changes them
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gi.enab_q <= qsr_pkg::QSR_ENAB_PRESET;
      gi.ptr_q  <= qsr_pkg::QSR_PTR_PRESET;
      gi.ntr_q  <= qsr_pkg::QSR_NTR_PRESET;
    end else if (gi.preset) begin
      gi.enab_q <= qsr_pkg::QSR_ENAB_PRESET;
      gi.ptr_q  <= qsr_pkg::QSR_PTR_PRESET;
      gi.ntr_q  <= qsr_pkg::QSR_NTR_PRESET;
    end else if (gi.wr_en) begin
      case (gi.wr_sel)
        qsr_pkg::QSR_R_ENAB: begin
          gi.enab_q <= gi.wr_data;
        end
        qsr_pkg::QSR_R_PTR: begin
          gi.ptr_q <= gi.wr_data;
        end
        qsr_pkg::QSR_R_NTR: begin
          gi.ntr_q <= gi.wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_event_latch: assert property (
    (|set_w) |=> ((gi.evt_q & $past(set_w)) == $past(set_w)))
    else $error("Transition did not latch an event bit");
  chk_event_clear: assert property (
    ((|gi.rd_clr) && set_w == qsr_pkg::QSR_ZERO) |=> ((gi.evt_q & $past(gi.rd_clr)) == qsr_pkg::QSR_ZERO))
    else $error("Event bits survived a read");
  chk_event_hold_zero: assert property (
    (gi.evt_q == qsr_pkg::QSR_ZERO && set_w == qsr_pkg::QSR_ZERO) |=> gi.evt_q == qsr_pkg::QSR_ZERO)
    else $error("Event bit appeared without a transition");
  chk_preset_values: assert property (
    gi.preset |=> (gi.enab_q == qsr_pkg::QSR_MAX && gi.ptr_q == qsr_pkg::QSR_MAX
                   && gi.ntr_q == qsr_pkg::QSR_MIN))
    else $error("Status preset left wrong filter values");
  chk_filters_stable: assert property (
    (!gi.wr_en && !gi.preset) |=> ($stable(gi.enab_q) && $stable(gi.ptr_q) && $stable(gi.ntr_q)))
    else $error("Filter or mask changed without a write");
  chk_enab_store: assert property (
    (gi.wr_en && !gi.preset && gi.wr_sel == qsr_pkg::QSR_R_ENAB) |=> gi.enab_q == $past(gi.wr_data))
    else $error("Enable mask write not stored");
  chk_ptr_store: assert property (
    (gi.wr_en && !gi.preset && gi.wr_sel == qsr_pkg::QSR_R_PTR) |=> gi.ptr_q == $past(gi.wr_data))
    else $error("Rising filter write not stored");
  chk_ntr_store: assert property (
    (gi.wr_en && !gi.preset && gi.wr_sel == qsr_pkg::QSR_R_NTR) |=> gi.ntr_q == $past(gi.wr_data))
    else $error("Falling filter write not stored");
  chk_summary_cause: assert property (
    ##1 gi.summary_q == |($past(gi.evt_q) & $past(gi.enab_q)))
    else $error("Summary does not follow enabled events");

endmodule : qsr_group

/* File: tb/qsr_host_model.sv */
// Bus controller model: APB master and condition pin source
`timescale 1ns/100ps
module qsr_host_model (
  input  wire logic        pclk,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic      [14:0] freq_cond,
  output logic      [14:0] lim_cond
);
  initial begin
    {paddr, psel, penable, pwrite, pwdata} = '0;
    freq_cond = 15'h0000;
    lim_cond  = 15'h0000;
  end

  // ----------------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------------
  // Controller encodes a value as the plain sum of bit weights
  function automatic logic [31:0] enc(input logic [1:0] bnd, input logic [15:0] v);
    return {14'h0000, bnd, v};
  endfunction : enc

  // Entered just after a rising edge; one idle edge at the end keeps drivers apart
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask : xfer

  task automatic set_cond(input int g, input logic [14:0] v);
    if (g == 0) freq_cond <= v;
    else lim_cond <= v;
  endtask : set_cond
endmodule : qsr_host_model

/* File: tb/qsr_top_tb.sv */
// Self-checking testbench for the status register block
`timescale 1ns/100ps
module qsr_top_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] freq_cond, lim_cond;
  logic        freq_summary, lim_summary, err;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #2.5 pclk = ~pclk;

  qsr_top i_qsr_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_cond(freq_cond), .lim_cond(lim_cond), .freq_summary(freq_summary), .lim_summary(lim_summary));
  qsr_host_model i_qsr_host_model (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_cond(freq_cond), .lim_cond(lim_cond));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] adr(input int g, input logic [4:0] ofs);
    return 8'(g << qsr_pkg::QSR_GRP_BIT) | {3'h0, ofs};
  endfunction : adr

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
    i_qsr_host_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
    cmp_val(what, exp, rd);
    cmp_val({what, " slverr"}, {31'h0, e}, {31'h0, err});
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] a, input logic [1:0] b, input logic [15:0] v, input logic e);
    i_qsr_host_model.xfer(1'b1, a, i_qsr_host_model.enc(b, v), rd, err);
    cmp_val("write slverr", {31'h0, e}, {31'h0, err});
  endtask : wr_chk

  // Condition pins need two sync edges, one latch edge and one summary edge
  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask : settle

  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults(input int g);
    rd_chk("enab", adr(g, qsr_pkg::QSR_OFS_ENAB), 32'h0000_7FFF, 1'b0);
    rd_chk("ptr", adr(g, qsr_pkg::QSR_OFS_PTR), 32'h0000_7FFF, 1'b0);
    rd_chk("ntr", adr(g, qsr_pkg::QSR_OFS_NTR), 32'h0000_0000, 1'b0);
  endtask : t_defaults

  task automatic t_rw(input int g);
    logic [4:0] ofs[3] = '{qsr_pkg::QSR_OFS_ENAB, qsr_pkg::QSR_OFS_PTR, qsr_pkg::QSR_OFS_NTR};
    foreach (ofs[i]) begin
      wr_chk(adr(g, ofs[i]), qsr_pkg::QSR_BND_NUM, 16'h4005, 1'b0);
      rd_chk("sum", adr(g, ofs[i]), 32'h0000_4005, 1'b0);
      wr_chk(adr(g, ofs[i]), qsr_pkg::QSR_BND_MAX, 16'h0000, 1'b0);
      rd_chk("max", adr(g, ofs[i]), 32'h0000_7FFF, 1'b0);
      wr_chk(adr(g, ofs[i]), qsr_pkg::QSR_BND_MIN, 16'h0000, 1'b0);
      rd_chk("min", adr(g, ofs[i]), 32'h0000_0000, 1'b0);
      wr_chk(adr(g, ofs[i]), qsr_pkg::QSR_BND_NUM, 16'h7FFF, 1'b0);
      rd_chk("top", adr(g, ofs[i]), 32'h0000_7FFF, 1'b0);
    end
  endtask : t_rw

  task automatic t_refuse();
    wr_chk(adr(0, qsr_pkg::QSR_OFS_NTR), qsr_pkg::QSR_BND_NUM, 16'h0012, 1'b0);
    wr_chk(adr(0, qsr_pkg::QSR_OFS_NTR), qsr_pkg::QSR_BND_NUM, 16'h8000, 1'b1);
    wr_chk(adr(0, qsr_pkg::QSR_OFS_NTR), qsr_pkg::QSR_BND_RSV, 16'h0000, 1'b1);
    rd_chk("ntr kept", adr(0, qsr_pkg::QSR_OFS_NTR), 32'h0000_0012, 1'b0);
    wr_chk(adr(1, qsr_pkg::QSR_OFS_COND), qsr_pkg::QSR_BND_NUM, 16'h0001, 1'b1);
    rd_chk("unmapped", 8'h34, 32'h0000_0000, 1'b1);
    rd_chk("unaligned", 8'h02, 32'h0000_0000, 1'b1);
  endtask : t_refuse

  task automatic t_cond();
    i_qsr_host_model.set_cond(0, 15'h2A51);
    i_qsr_host_model.set_cond(1, 15'h4C03);
    settle();
    repeat (2) rd_chk("freq cond", adr(0, qsr_pkg::QSR_OFS_COND), 32'h0000_2A51, 1'b0);
    repeat (2) rd_chk("lim cond", adr(1, qsr_pkg::QSR_OFS_COND), 32'h0000_4C03, 1'b0);
  endtask : t_cond

  task automatic t_events(input int g);
    wr_chk(adr(g, qsr_pkg::QSR_OFS_PTR), qsr_pkg::QSR_BND_MAX, 16'h0000, 1'b0);
    wr_chk(adr(g, qsr_pkg::QSR_OFS_NTR), qsr_pkg::QSR_BND_MIN, 16'h0000, 1'b0);
    wr_chk(adr(g, qsr_pkg::QSR_OFS_ENAB), qsr_pkg::QSR_BND_MIN, 16'h0000, 1'b0);
    i_qsr_host_model.set_cond(g, 15'h0000);
    settle();
    i_qsr_host_model.xfer(1'b0, adr(g, qsr_pkg::QSR_OFS_EVENT), 32'h0000_0000, rd, err);
    i_qsr_host_model.set_cond(g, 15'h0005);
    settle();
    cmp_val("masked summary", 32'h0, {31'h0, g == 0 ? freq_summary : lim_summary});
    wr_chk(adr(g, qsr_pkg::QSR_OFS_ENAB), qsr_pkg::QSR_BND_NUM, 16'h0004, 1'b0);
    settle();
    cmp_val("summary", 32'h1, {31'h0, g == 0 ? freq_summary : lim_summary});
    i_qsr_host_model.xfer(1'b0, qsr_pkg::QSR_SUMM_OFS, 32'h0000_0000, rd, err);
    cmp_val("summary reg", 32'h1, {31'h0, rd[g]});
    rd_chk("event", adr(g, qsr_pkg::QSR_OFS_EVENT), 32'h0000_0005, 1'b0);
    rd_chk("event cleared", adr(g, qsr_pkg::QSR_OFS_EVENT), 32'h0000_0000, 1'b0);
    settle();
    cmp_val("summary cleared", 32'h0, {31'h0, g == 0 ? freq_summary : lim_summary});
    wr_chk(adr(g, qsr_pkg::QSR_OFS_PTR), qsr_pkg::QSR_BND_MIN, 16'h0000, 1'b0);
    wr_chk(adr(g, qsr_pkg::QSR_OFS_NTR), qsr_pkg::QSR_BND_NUM, 16'h0001, 1'b0);
    i_qsr_host_model.set_cond(g, 15'h0000);
    settle();
    rd_chk("fall event", adr(g, qsr_pkg::QSR_OFS_EVENT), 32'h0000_0001, 1'b0);
    rd_chk("still clear", adr(g, qsr_pkg::QSR_OFS_EVENT), 32'h0000_0000, 1'b0);
  endtask : t_events

  task automatic t_preset();
    wr_chk(qsr_pkg::QSR_CTRL_OFS, qsr_pkg::QSR_BND_NUM, 16'h0000, 1'b0);
    rd_chk("ntr kept", adr(1, qsr_pkg::QSR_OFS_NTR), 32'h0000_0001, 1'b0);
    wr_chk(qsr_pkg::QSR_CTRL_OFS, qsr_pkg::QSR_BND_NUM, 16'h0001, 1'b0);
    t_defaults(0);
    t_defaults(1);
  endtask : t_preset

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults(0);
    t_defaults(1);
    t_rw(0);
    t_rw(1);
    t_refuse();
    t_cond();
    t_events(0);
    t_events(1);
    t_preset();
    wrap_up();
  end

  // Whole run needs well under 1500 cycles
  initial begin
    #(5 * 5000);
    error_cnt++;
    wrap_up();
  end
endmodule : qsr_top_tb
